// ---- rtl/comparator_control_logic.sv ----
// comparator control: input select, result sync, interrupt and capture routing, Wishbone registers
`timescale 1ns/1ps
`default_nettype none
module comparator_control_logic
	import comparator_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        reset,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        analogHigher,
	input  wire logic        globalIrqEnable,
	input  wire logic        irqVectorAck,
	input  wire logic        positivePinIn,
	input  wire logic        negativePinIn,
	output logic             positivePortBit,
	output logic             negativePortBit,
	output logic             positiveBufferOn,
	output logic             negativeBufferOn,
	output logic             comparatorPowerOn,
	output logic             bandgapToPositive,
	output logic             negativeFromChannel,
	output logic [2:0]       negativeChannel,
	output logic             converterEnable,
	output logic             converterPowerReduction,
	output logic [2:0]       autoTriggerSelect,
	output logic             captureInput,
	output logic             comparatorIrq,
	output logic             eventIrq
);
	// limitations: only byte lane 0 carries data and a write with sel[0] low is
	// dropped; unmapped addresses still answer, so a stray access never hangs the bus

	////////////////////////////////////////////////////////////////////////
	// register state
	logic [7:0]           ctrl_q;
	logic                 flag_q;
	logic                 muxEnable_q;
	logic [TRIG_WIDTH-1:0] trigSel_q;
	logic [1:0]           pinOff_q;
	logic                 convEn_q;
	logic                 convPr_q;
	logic [CHAN_WIDTH-1:0] chan_q;
	logic [EVT_WIDTH-1:0] evtStatus_q;
	logic [EVT_WIDTH-1:0] evtMask_q;
	logic                 ack_q;
	logic [31:0]          rdata_q;
	logic                 captureRoute_q;

	logic syncResult;
	logic riseSeen;
	logic fallSeen;

	////////////////////////////////////////////////////////////////////////
	// bus decode
	wire access    = wb_cyc_i & wb_stb_i & ~ack_q;
	wire wrByte0   = access & wb_we_i & wb_sel_i[0];
	// register select codes; unmapped addresses decode to none
	typedef enum logic [2:0] {
		SEL_NONE   = 3'b000,
		SEL_CTRL   = 3'b001,
		SEL_CONV_B = 3'b010,
		SEL_PIN    = 3'b011,
		SEL_CONV_A = 3'b100,
		SEL_CHAN   = 3'b101,
		SEL_EVT    = 3'b110,
		SEL_MASK   = 3'b111
	} reg_sel_type;

	// address to register select, shared by the write and read paths
	function automatic reg_sel_type regOf(input logic [7:0] adr);
		reg_sel_type sel;
		if (adr == CTRL_STATUS_ADDR) begin
			sel = SEL_CTRL;
		end else if (adr == CONV_CTRL_B_ADDR) begin
			sel = SEL_CONV_B;
		end else if (adr == PIN_DISABLE_ADDR) begin
			sel = SEL_PIN;
		end else if (adr == CONV_CTRL_A_ADDR) begin
			sel = SEL_CONV_A;
		end else if (adr == CHAN_SEL_ADDR) begin
			sel = SEL_CHAN;
		end else if (adr == EVT_STATUS_ADDR) begin
			sel = SEL_EVT;
		end else if (adr == EVT_MASK_ADDR) begin
			sel = SEL_MASK;
		end else begin
			sel = SEL_NONE;
		end
		return sel;
	endfunction

	// one hit per register; the read mux and each write enable share them
	wire hitCtrl   = (regOf(wb_adr_i) == SEL_CTRL);
	wire hitConvB  = (regOf(wb_adr_i) == SEL_CONV_B);
	wire hitPin    = (regOf(wb_adr_i) == SEL_PIN);
	wire hitConvA  = (regOf(wb_adr_i) == SEL_CONV_A);
	wire hitChan   = (regOf(wb_adr_i) == SEL_CHAN);
	wire hitEvt    = (regOf(wb_adr_i) == SEL_EVT);
	wire hitMask   = (regOf(wb_adr_i) == SEL_MASK);
	wire wrCtrl    = wrByte0 & hitCtrl;

	////////////////////////////////////////////////////////////////////////
	// synchroniser and edge detection; a powered-off comparator reads low
	wire rawGated = analogHigher & comparatorPowerOn;
	result_sync syncUnit (
		.core_clk (core_clk),
		.reset    (reset),
		.rawIn    (rawGated),
		.syncOut  (syncResult),
		.riseSeen (riseSeen),
		.fallSeen (fallSeen)
	);

	// mode comes from the stored control byte, so a rewrite acts from the next cycle
	// event decode per mode; reserved code matches nothing
	irq_mode_type mode;
	assign mode = irq_mode_type'(ctrl_q[MODE_HI_BIT:MODE_LO_BIT]);
	wire modeEvent = (mode == MODE_TOGGLE) ? (riseSeen | fallSeen) :
	                 (mode == MODE_FALL)   ? fallSeen :
	                 (mode == MODE_RISE)   ? riseSeen :
	                 1'b0;

	// clear on one-write or vector ack; a new event wins over clear
	wire flagClear = (wrCtrl & wb_dat_i[FLAG_BIT]) | irqVectorAck;
	wire flagNext  = modeEvent | (flag_q & ~flagClear);

	always_ff @(posedge core_clk) begin
		if (reset) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= flagNext;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// writable fields
	// control byte: power, bandgap, enable, capture route and mode;
	// the result and flag positions are stored but never read back
	always_ff @(posedge core_clk) begin
		if (reset) begin
			ctrl_q <= RESET_BYTE;
		end else if (wrByte0 && hitCtrl) begin
			ctrl_q <= wb_dat_i[7:0];
		end
	end

	// mux borrow request and auto trigger select
	always_ff @(posedge core_clk) begin
		if (reset) begin
			muxEnable_q <= 1'b0;
			trigSel_q   <= '0;
		end else if (wrByte0 && hitConvB) begin
			muxEnable_q <= wb_dat_i[MUX_EN_BIT];
			trigSel_q   <= wb_dat_i[TRIG_LO_BIT +: TRIG_WIDTH];
		end
	end

	// pin buffer disables; upper bits are not stored at all
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pinOff_q <= 2'b00;
		end else if (wrByte0 && hitPin) begin
			pinOff_q <= {wb_dat_i[NEG_OFF_BIT], wb_dat_i[POS_OFF_BIT]};
		end
	end

	// own converter word: enable and power reduction; the converter itself
	// lives outside, these bits only steer it
	always_ff @(posedge core_clk) begin
		if (reset) begin
			convEn_q <= 1'b0;
			convPr_q <= 1'b0;
		end else if (wrByte0 && hitConvA) begin
			convEn_q <= wb_dat_i[CONV_EN_BIT];
			convPr_q <= wb_dat_i[CONV_PR_BIT];
		end
	end

	// channel select for the borrowed negative input
	always_ff @(posedge core_clk) begin
		if (reset) begin
			chan_q <= '0;
		end else if (wrByte0 && hitChan) begin
			chan_q <= wb_dat_i[CHAN_WIDTH-1:0];
		end
	end

	// event mask
	always_ff @(posedge core_clk) begin
		if (reset) begin
			evtMask_q <= '0;
		end else if (wrByte0 && hitMask) begin
			evtMask_q <= wb_dat_i[EVT_WIDTH-1:0];
		end
	end

	// sticky event status: comparator event, write-one-to-clear, set wins
	wire [EVT_WIDTH-1:0] evtSet = modeEvent;
	wire [EVT_WIDTH-1:0] evtClr = (wrByte0 & hitEvt) ? wb_dat_i[EVT_WIDTH-1:0] : '0;
	always_ff @(posedge core_clk) begin
		if (reset) begin
			evtStatus_q <= '0;
		end else begin
			evtStatus_q <= evtSet | (evtStatus_q & ~evtClr);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// readback mux
	wire [7:0] ctrlRead = {ctrl_q[POWER_OFF_BIT], ctrl_q[BANDGAP_BIT], syncResult, flag_q,
	                       ctrl_q[IRQ_EN_BIT], ctrl_q[CAPTURE_BIT], ctrl_q[MODE_HI_BIT],
	                       ctrl_q[MODE_LO_BIT]};
	wire [7:0] convBRead = {1'b0, muxEnable_q, 3'h0, trigSel_q};
	wire [7:0] pinRead   = {6'h00, pinOff_q};
	wire [7:0] convARead = {6'h00, convPr_q, convEn_q};
	wire [7:0] chanRead  = {5'h00, chan_q};
	wire [7:0] evtRead   = {7'h00, evtStatus_q};
	wire [7:0] maskRead  = {7'h00, evtMask_q};
	wire [7:0] readByte  = hitCtrl  ? ctrlRead  :
	                       hitConvB ? convBRead :
	                       hitPin   ? pinRead   :
	                       hitConvA ? convARead :
	                       hitChan  ? chanRead  :
	                       hitEvt   ? evtRead   :
	                       hitMask  ? maskRead  :
	                       8'h00;

	// one-cycle answer; unmapped reads return zero, writes are dropped
	always_ff @(posedge core_clk) begin
		if (reset) begin
			ack_q   <= 1'b0;
			rdata_q <= 32'h00000000;
		end else begin
			ack_q   <= access;
			rdata_q <= access ? {24'h000000, readByte} : rdata_q;
		end
	end

	// capture route is registered so the timer sees a clean level
	always_ff @(posedge core_clk) begin
		if (reset) begin
			captureRoute_q <= 1'b0;
		end else begin
			captureRoute_q <= ctrl_q[CAPTURE_BIT] & syncResult;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// bus and analog control outputs
	assign wb_ack_o                = ack_q;
	assign wb_dat_o                = rdata_q;
	assign comparatorPowerOn       = ~ctrl_q[POWER_OFF_BIT];
	assign bandgapToPositive       = ctrl_q[BANDGAP_BIT];
	assign negativeFromChannel     = muxEnable_q & ~convEn_q;
	assign negativeChannel         = chan_q;
	assign converterEnable         = convEn_q;
	assign converterPowerReduction = convPr_q;
	assign autoTriggerSelect       = trigSel_q;
	assign captureInput            = captureRoute_q;
	// analog compare itself happens outside; the selects above steer it

	////////////////////////////////////////////////////////////////////////
	// interrupt requests: level outputs, low whenever their enable is off
	assign comparatorIrq = flag_q & ctrl_q[IRQ_EN_BIT] & globalIrqEnable;
	// sticky event summary behind its mask
	assign eventIrq      = |(evtStatus_q & evtMask_q);

	// digital buffers: disabled pins read zero
	assign positiveBufferOn = ~pinOff_q[POS_OFF_BIT];
	assign negativeBufferOn = ~pinOff_q[NEG_OFF_BIT];
	assign positivePortBit  = positivePinIn & ~pinOff_q[POS_OFF_BIT];
	assign negativePortBit  = negativePinIn & ~pinOff_q[NEG_OFF_BIT];
endmodule
`default_nettype wire

// ---- rtl/comparator_pkg.sv ----
// package: register map, field positions and encodings of the comparator control block
package comparator_pkg;

	// register byte addresses (Wishbone, one word each; all word aligned except 0x7b)
	localparam logic [7:0] CTRL_STATUS_ADDR  = 8'h50;
	localparam logic [7:0] CONV_CTRL_B_ADDR  = 8'h7b;
	localparam logic [7:0] PIN_DISABLE_ADDR  = 8'h7c;
	localparam logic [7:0] CONV_CTRL_A_ADDR  = 8'h80;
	localparam logic [7:0] CHAN_SEL_ADDR     = 8'h84;
	localparam logic [7:0] EVT_STATUS_ADDR   = 8'h88;
	localparam logic [7:0] EVT_MASK_ADDR     = 8'h8c;

	// comparator_control_status fields
	localparam int POWER_OFF_BIT = 7;
	localparam int BANDGAP_BIT   = 6;
	localparam int RESULT_BIT    = 5;
	localparam int FLAG_BIT      = 4;
	localparam int IRQ_EN_BIT    = 3;
	localparam int CAPTURE_BIT   = 2;
	localparam int MODE_HI_BIT   = 1;
	localparam int MODE_LO_BIT   = 0;

	// converter_control_status_b fields
	localparam int MUX_EN_BIT    = 6;
	localparam int TRIG_LO_BIT   = 0;
	localparam int TRIG_WIDTH    = 3;

	// own converter control word: enable and power reduction
	localparam int CONV_EN_BIT   = 0;
	localparam int CONV_PR_BIT   = 1;

	// pin disable fields
	localparam int POS_OFF_BIT   = 0;
	localparam int NEG_OFF_BIT   = 1;

	// event status bits
	localparam int EVT_COMPARE   = 0;
	localparam int EVT_WIDTH     = 1;

	localparam int CHAN_WIDTH    = 3;
	localparam int NUM_CHANNELS  = 8;

	localparam logic [7:0] RESET_BYTE = 8'h00;

	typedef enum logic [1:0] {
		MODE_TOGGLE   = 2'b00,
		MODE_RESERVED = 2'b01,
		MODE_FALL     = 2'b10,
		MODE_RISE     = 2'b11
	} irq_mode_type;

endpackage

// ---- rtl/result_sync.sv ----
// two-flop synchroniser with edge detect for the comparator output
`timescale 1ns/1ps
`default_nettype none
module result_sync (
	input  wire logic core_clk,
	input  wire logic reset,
	input  wire logic rawIn,
	output logic      syncOut,
	output logic      riseSeen,
	output logic      fallSeen
);
	logic meta_q;
	logic sync_q;
	logic prev_q;

	// first flop feeds only the second
	always_ff @(posedge core_clk) begin
		if (reset) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			prev_q <= 1'b0;
		end else begin
			meta_q <= rawIn;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	// compare with previous sample so each transition fires once
	assign syncOut  = sync_q;
	assign riseSeen = sync_q & ~prev_q;
	assign fallSeen = ~sync_q & prev_q;
endmodule
`default_nettype wire

// ---- tb/comparator_control_logic_asserts.sv ----
// checker: port-level assertions for the comparator control block
`timescale 1ns/1ps
`default_nettype none
module comparator_control_logic_asserts (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic analogHigher,
	input wire logic globalIrqEnable,
	input wire logic irqVectorAck,
	input wire logic positivePinIn,
	input wire logic negativePinIn,
	input wire logic positivePortBit,
	input wire logic negativePortBit,
	input wire logic positiveBufferOn,
	input wire logic negativeBufferOn,
	input wire logic negativeFromChannel,
	input wire logic converterEnable,
	input wire logic captureInput,
	input wire logic comparatorIrq,
	input wire logic eventIrq
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	logic [2:0] rawHist_q;
	// raw history: a vector clear is only judged when no event is in flight
	always_ff @(posedge core_clk) rawHist_q <= {rawHist_q[1:0], analogHigher};
	wire quiet = (&{rawHist_q, analogHigher}) || !(|{rawHist_q, analogHigher});
	a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
	a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
	a_ack_has_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
	a_pos_port_gate: assert property (positivePortBit == (positivePinIn && positiveBufferOn))
		else $error("positive port bit wrong");
	a_neg_port_gate: assert property (negativePortBit == (negativePinIn && negativeBufferOn))
		else $error("negative port bit wrong");
	a_irq_needs_gie: assert property (comparatorIrq |-> globalIrqEnable) else $error("irq without global");
	a_mux_borrow: assert property (negativeFromChannel |-> !converterEnable) else $error("mux borrowed");
	a_capture_path: assert property (captureInput |-> $past(analogHigher, 3)) else $error("capture early");
	a_vector_clear: assert property (irqVectorAck && quiet |=> !comparatorIrq) else $error("vector kept irq");
	c_irq: cover property ($rose(comparatorIrq));
	c_capture: cover property ($rose(captureInput));
	c_event: cover property ($rose(eventIrq));
endmodule
bind comparator_control_logic comparator_control_logic_asserts u_asserts (.*);
`default_nettype wire

// ---- tb/comparator_control_logic_test.sv ----
// testbench: register-level tests of the comparator control block
`timescale 1ns/1ps
`default_nettype none
module comparator_control_logic_test import comparator_pkg::*; ;
	logic core_clk = 0, reset = 1, cyc = 0, stb = 0, we = 0, gie = 0, vecAck = 0, pins = 1;
	logic [7:0] adr = 0, posLvl = 0, negLvl = 8'h80;
	logic [31:0] dat = 0, datO;
	logic ack, ah, ppb, npb, pbo, nbo, pwr, bg, nfc, cen, cpr, cap, irq, evIrq;
	logic [2:0] nch, ats;
	int miscompares = 0, compares = 0, capCount, m;
	comparator_control_logic DUT (.core_clk, .reset, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(datO), .wb_ack_o(ack), .analogHigher(ah),
		.globalIrqEnable(gie), .irqVectorAck(vecAck), .positivePinIn(pins), .negativePinIn(pins),
		.positivePortBit(ppb), .negativePortBit(npb), .positiveBufferOn(pbo), .negativeBufferOn(nbo),
		.comparatorPowerOn(pwr), .bandgapToPositive(bg), .negativeFromChannel(nfc), .negativeChannel(nch),
		.converterEnable(cen), .converterPowerReduction(cpr), .autoTriggerSelect(ats),
		.captureInput(cap), .comparatorIrq(irq), .eventIrq(evIrq));
	comparator_partner far (.core_clk, .posLevel(posLvl), .negLevel(negLvl), .captureIrqEnable(1'h1),
		.captureInput(cap), .analogHigher(ah), .captureEvents(capCount));
	initial forever #2.5 core_clk = ~core_clk;
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
		end
	endtask
	// one classic cycle; a read compares the returned byte with d
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n = 0;
		@(posedge core_clk);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		dat <= {24'h0, d};
		@(posedge core_clk);
		while (ack !== 1'h1 && n < 20) begin
			@(posedge core_clk);
			n++;
		end
		chk(ack, 1'h1); // a wait that runs out is a mismatch
		if (!w) chk(datO, {24'h0, d});
		cyc <= 1'h0;
		stb <= 1'h0;
		we <= 1'h0;
	endtask
	// the synchroniser needs two edges and the flag a third; six leaves margin
	task automatic settle;
		repeat (6) @(posedge core_clk);
	endtask
	task automatic report_and_stop;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (10) @(posedge core_clk);
		reset <= 1'h0;
		xfer(0, CTRL_STATUS_ADDR, 8'h00);
		xfer(0, CONV_CTRL_B_ADDR, 8'h00);
		xfer(0, 8'h90, 8'h00);
		xfer(1, PIN_DISABLE_ADDR, 8'hff);
		xfer(0, PIN_DISABLE_ADDR, 8'h03);
		chk({pbo, nbo, ppb, npb}, 4'h0);
		xfer(1, PIN_DISABLE_ADDR, 8'h00);
		chk({pbo, nbo, ppb, npb}, 4'hf);
		xfer(1, CTRL_STATUS_ADDR, 8'hc0);
		chk({pwr, bg}, 2'h1);
		xfer(1, CTRL_STATUS_ADDR, 8'h00);
		chk({pwr, bg}, 2'h2);
		xfer(1, CONV_CTRL_B_ADDR, 8'h47);
		xfer(1, CHAN_SEL_ADDR, 8'h05);
		chk({nfc, nch, ats, cen, cpr}, 9'h1bc);
		xfer(1, CONV_CTRL_A_ADDR, 8'h03);
		chk({nfc, cen, cpr}, 3'h3);
		$display("static tests done");
		// each mode against a rise then a fall of the result
		for (m = 0; m < 4; m++) begin
			xfer(1, CTRL_STATUS_ADDR, 8'h10 | m[7:0]);
			posLvl <= 8'hff;
			settle();
			xfer(0, CTRL_STATUS_ADDR, {3'h1, m == 0 || m == 3, 2'h0, m[1:0]});
			xfer(1, CTRL_STATUS_ADDR, 8'h10 | m[7:0]);
			posLvl <= 8'h00;
			settle();
			xfer(0, CTRL_STATUS_ADDR, {3'h0, m == 0 || m == 2, 2'h0, m[1:0]});
		end
		$display("mode tests done");
		xfer(1, CTRL_STATUS_ADDR, 8'h00);
		posLvl <= 8'hff;
		settle();
		xfer(1, CTRL_STATUS_ADDR, 8'h08);
		xfer(0, CTRL_STATUS_ADDR, 8'h38);
		chk(irq, 1'h0);
		gie <= 1'h1;
		@(posedge core_clk);
		chk(irq, 1'h1);
		vecAck <= 1'h1;
		@(posedge core_clk);
		vecAck <= 1'h0;
		@(posedge core_clk);
		chk(irq, 1'h0);
		posLvl <= 8'h00;
		settle();
		xfer(1, CTRL_STATUS_ADDR, 8'h18);
		xfer(0, CTRL_STATUS_ADDR, 8'h08);
		// sticky event status behind its mask
		xfer(1, EVT_MASK_ADDR, 8'h01);
		settle();
		chk(evIrq, 1'h1);
		xfer(1, EVT_STATUS_ADDR, 8'h01);
		xfer(0, EVT_STATUS_ADDR, 8'h00);
		settle();
		chk(evIrq, 1'h0);
		$display("irq tests done");
		xfer(1, CTRL_STATUS_ADDR, 8'h04);
		posLvl <= 8'hff;
		settle();
		chk({cap, capCount[3:0]}, 5'h11);
		xfer(1, CTRL_STATUS_ADDR, 8'h00);
		settle();
		chk(cap, 1'h0);
		$display("capture test done");
		// powering off forces the result low, and that fall is itself an event
		xfer(1, CTRL_STATUS_ADDR, 8'h90);
		settle();
		xfer(0, CTRL_STATUS_ADDR, 8'h90);
		$display("power test done");
		report_and_stop();
	end
	// watchdog well past the few hundred cycles the tests need
	initial begin
		#100000;
		miscompares++;
		report_and_stop();
	end
endmodule
`default_nettype wire

// ---- tb/comparator_partner.sv ----
// partner model: analog levels at the comparator inputs and the timer capture front end
`timescale 1ns/1ps
`default_nettype none
module comparator_partner (
	input  wire logic       core_clk,
	input  wire logic [7:0] posLevel,
	input  wire logic [7:0] negLevel,
	input  wire logic       captureIrqEnable,
	input  wire logic       captureInput,
	output logic            analogHigher,
	output int              captureEvents
);
	logic lastCapture_q;
	// strict compare: equal levels read as low
	assign analogHigher = posLevel > negLevel;
	// timer counts rises only while its capture interrupt is enabled
	initial captureEvents = 0;
	always @(posedge core_clk) begin
		lastCapture_q <= captureInput;
		if (captureIrqEnable && captureInput && !lastCapture_q)
			captureEvents <= captureEvents + 1;
	end
endmodule
`default_nettype wire
